// [rtl/dtmfg_map.svh]
// Register map, field positions and timing counts of the DTMF generator
`ifndef DTMFG_MAP_SVH
`define DTMFG_MAP_SVH
// Byte offsets on the register bus
`define DTMF_ADDR_TXDATA 8'h00
`define DTMF_ADDR_RXDATA 8'h04
`define DTMF_ADDR_CTRL 8'h08
`define DTMF_ADDR_STATUS 8'h0C
// Status bit positions
`define DTMF_ST_IRQ 0
`define DTMF_ST_TXRDY 1
`define DTMF_ST_RXVAL 2
`define DTMF_ST_HELD 3
// Reset values
`define DTMF_CTRL_RST 4'h0
`define DTMF_TXRDY_RST 1'b1
`define DTMF_ROM_RST 8'h80
// Tone geometry
`define DTMF_SEG_BITS 5
`define DTMF_DIV_BITS 8
// Crystal divide ratios per segment, row group then column group
`define DTMF_DIV_L1 8'hA0
`define DTMF_DIV_L2 8'h92
`define DTMF_DIV_L3 8'h84
`define DTMF_DIV_L4 8'h76
`define DTMF_DIV_H1 8'h5C
`define DTMF_DIV_H2 8'h54
`define DTMF_DIV_H3 8'h4C
`define DTMF_DIV_H4 8'h44
// Times in ms and their counts in crystal ticks
`define DTMF_XTAL_HZ 3579545
`define DTMF_BURST_MS 51
`define DTMF_BURST_TICKS ((`DTMF_XTAL_HZ * `DTMF_BURST_MS) / 1000)
`define DTMF_REC_MS 40
`define DTMF_REC_TICKS ((`DTMF_XTAL_HZ * `DTMF_REC_MS + 999) / 1000)
`define DTMF_DO_MS 10
`define DTMF_DO_TICKS ((`DTMF_XTAL_HZ * `DTMF_DO_MS) / 1000)
`define DTMF_ID_MS 40
`define DTMF_ID_TICKS ((`DTMF_XTAL_HZ * `DTMF_ID_MS + 999) / 1000)
`endif

// [rtl/dtmfg_pkg.sv]
// Types shared by the DTMF generator modules
package dtmfg_pkg;
  // Control register fields, bit 3 down to bit 0
  typedef struct packed {
    logic burst_enable;
    logic irq_enable;
    logic call_progress_select;
    logic tone_output_enable;
  } dtmfg_ctrl_s;
  // Row and column group indices of a digit
  typedef struct packed {
    logic [1:0] row;
    logic [1:0] col;
  } dtmfg_grp_s;
  typedef enum logic [1:0] {BST_IDLE, BST_TONE, BST_PAUSE} dtmfg_burst_e;
  typedef enum logic [1:0] {RX_IDLE, RX_HELD, RX_GAP} dtmfg_rx_e;
endpackage : dtmfg_pkg

// [rtl/dtmfg_sine_rom.sv]
// Sine lookup table with registered output
`timescale 1ns/1ns
`include "dtmfg_map.svh"
module dtmfg_sine_rom (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [`DTMF_SEG_BITS-1:0] addr,
  output logic [7:0] data
);
  logic [7:0] val;

  // One full period in 32 unsigned samples
  always_comb begin
    case (addr)
      5'd0: val = 8'h80;
      5'd1: val = 8'h99;
      5'd2: val = 8'hB1;
      5'd3: val = 8'hC7;
      5'd4: val = 8'hDA;
      5'd5: val = 8'hEA;
      5'd6: val = 8'hF5;
      5'd7: val = 8'hFD;
      5'd8: val = 8'hFF;
      5'd9: val = 8'hFD;
      5'd10: val = 8'hF5;
      5'd11: val = 8'hEA;
      5'd12: val = 8'hDA;
      5'd13: val = 8'hC7;
      5'd14: val = 8'hB1;
      5'd15: val = 8'h99;
      5'd16: val = 8'h80;
      5'd17: val = 8'h67;
      5'd18: val = 8'h4F;
      5'd19: val = 8'h39;
      5'd20: val = 8'h26;
      5'd21: val = 8'h16;
      5'd22: val = 8'h0B;
      5'd23: val = 8'h03;
      5'd24: val = 8'h01;
      5'd25: val = 8'h03;
      5'd26: val = 8'h0B;
      5'd27: val = 8'h16;
      5'd28: val = 8'h26;
      5'd29: val = 8'h39;
      5'd30: val = 8'h4F;
      default: val = 8'h67;
    endcase
  end

  // Registered read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data <= `DTMF_ROM_RST;
    end else begin
      data <= val;
    end
  end
endmodule : dtmfg_sine_rom

// [rtl/dtmfg_tone_path.sv]
// Programmable divider and segment counter of one tone
`timescale 1ns/1ns
`include "dtmfg_map.svh"
module dtmfg_tone_path #(
  parameter int DIV_W = `DTMF_DIV_BITS,
  parameter int SEG_W = `DTMF_SEG_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [DIV_W-1:0] term,
  output logic [SEG_W-1:0] seg_addr
);
  logic [DIV_W-1:0] div_r;
  logic seg_pulse;

  // Terminal count reached on a crystal tick
  assign seg_pulse = run && tick && (div_r == term);

  // Divider restarts from zero at terminal count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= '0;
    end else if (!run) begin
      div_r <= '0;
    end else if (seg_pulse) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= div_r + 1'b1;
    end
  end

  // Segment counter wraps after 32 segments
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_addr <= '0;
    end else if (!run) begin
      seg_addr <= '0;
    end else if (seg_pulse) begin
      seg_addr <= seg_addr + 1'b1;
    end
  end
endmodule : dtmfg_tone_path

// [rtl/dtmfg_top.sv]
// DTMF transmitter with burst timing, receive latch and AHB-Lite registers
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "dtmfg_map.svh"
module dtmfg_top #(
  parameter int BURST_TICKS = `DTMF_BURST_TICKS,
  parameter int REC_TICKS = `DTMF_REC_TICKS,
  parameter int DO_TICKS = `DTMF_DO_TICKS,
  parameter int ID_TICKS = `DTMF_ID_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic xtal_clk_pin,
  input wire logic rx_tone_present,
  input wire logic [3:0] rx_tone_code,
  input wire logic call_progress_level,
  output logic [7:0] row_level,
  output logic [7:0] column_level,
  output logic tone_active,
  output logic interrupt_or_tone_square_out,
  output logic interrupt_or_tone_square_oe
);
  localparam int CNT_W = 20;

  logic xtal_s1_r, xtal_s2_r, xtal_s3_r;
  logic rxp_s1_r, rxp_s2_r;
  logic [3:0] rxc_s1_r, rxc_s2_r;
  logic cpl_s1_r, cpl_s2_r;
  logic tick;
  logic addr_ok, rd_stat, wr_tx, wr_ctrl;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_nxt;
  dtmfg_pkg::dtmfg_ctrl_s ctrl_r;
  logic [3:0] tx_digit_r;
  logic tx_go_r;
  dtmfg_pkg::dtmfg_grp_s grp;
  logic [7:0] row_term, col_term;
  dtmfg_pkg::dtmfg_burst_e bst_st_r;
  logic [CNT_W-1:0] bst_cnt_r;
  logic [CNT_W-1:0] bst_lim;
  logic burst_on, bst_end, bst_done, tone_run;
  dtmfg_pkg::dtmfg_rx_e rx_st_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic rx_latch;
  logic [3:0] rx_digit_r;
  logic tx_ready_r, rx_valid_r, irq_pend_r;
  logic [4:0] row_seg, col_seg;

  // Digit code to row and column index, shared code table
  function automatic dtmfg_pkg::dtmfg_grp_s digit_grp(input logic [3:0] c);
    dtmfg_pkg::dtmfg_grp_s g;
    g = '0;
    case (c)
      4'h1: g = '{row: 2'd0, col: 2'd0};
      4'h2: g = '{row: 2'd0, col: 2'd1};
      4'h3: g = '{row: 2'd0, col: 2'd2};
      4'hD: g = '{row: 2'd0, col: 2'd3};
      4'h4: g = '{row: 2'd1, col: 2'd0};
      4'h5: g = '{row: 2'd1, col: 2'd1};
      4'h6: g = '{row: 2'd1, col: 2'd2};
      4'hE: g = '{row: 2'd1, col: 2'd3};
      4'h7: g = '{row: 2'd2, col: 2'd0};
      4'h8: g = '{row: 2'd2, col: 2'd1};
      4'h9: g = '{row: 2'd2, col: 2'd2};
      4'hF: g = '{row: 2'd2, col: 2'd3};
      4'hB: g = '{row: 2'd3, col: 2'd0};
      4'hA: g = '{row: 2'd3, col: 2'd1};
      4'hC: g = '{row: 2'd3, col: 2'd2};
      default: g = '{row: 2'd3, col: 2'd3};
    endcase
    return g;
  endfunction : digit_grp

  // Terminal count for a group index, row or column group
  function automatic logic [7:0] div_term(input logic hi,
                                          input logic [1:0] idx);
    logic [7:0] d;
    d = `DTMF_DIV_L1;
    case ({hi, idx})
      3'd0: d = `DTMF_DIV_L1;
      3'd1: d = `DTMF_DIV_L2;
      3'd2: d = `DTMF_DIV_L3;
      3'd3: d = `DTMF_DIV_L4;
      3'd4: d = `DTMF_DIV_H1;
      3'd5: d = `DTMF_DIV_H2;
      3'd6: d = `DTMF_DIV_H3;
      default: d = `DTMF_DIV_H4;
    endcase
    return d - 8'h01;
  endfunction : div_term

  // Crystal pin synchroniser and rising edge tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_s3_r <= 1'b0;
    end else begin
      xtal_s1_r <= xtal_clk_pin;
      xtal_s2_r <= xtal_s1_r;
      xtal_s3_r <= xtal_s2_r;
    end
  end
  assign tick = xtal_s2_r && !xtal_s3_r;

  // Detector and comparator pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxp_s1_r <= 1'b0;
      rxp_s2_r <= 1'b0;
      rxc_s1_r <= 4'h0;
      rxc_s2_r <= 4'h0;
      cpl_s1_r <= 1'b1;
      cpl_s2_r <= 1'b1;
    end else begin
      rxp_s1_r <= rx_tone_present;
      rxp_s2_r <= rxp_s1_r;
      rxc_s1_r <= rx_tone_code;
      rxc_s2_r <= rxc_s1_r;
      cpl_s1_r <= call_progress_level;
      cpl_s2_r <= cpl_s1_r;
    end
  end

  // Bus address phase decode
  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_stat = addr_ok && !hwrite &&
                   (haddr[7:0] == `DTMF_ADDR_STATUS);
  assign wr_tx = wr_pend_r && (wr_addr_r == `DTMF_ADDR_TXDATA);
  assign wr_ctrl = wr_pend_r && (wr_addr_r == `DTMF_ADDR_CTRL);

  // Write address held into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Read data selection
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (haddr[7:0] == `DTMF_ADDR_RXDATA) begin
      rd_nxt[3:0] = rx_digit_r;
    end else if (haddr[7:0] == `DTMF_ADDR_CTRL) begin
      rd_nxt[3:0] = ctrl_r;
    end else if (haddr[7:0] == `DTMF_ADDR_STATUS) begin
      rd_nxt[`DTMF_ST_IRQ] = irq_pend_r;
      rd_nxt[`DTMF_ST_TXRDY] = tx_ready_r;
      rd_nxt[`DTMF_ST_RXVAL] = rx_valid_r;
      rd_nxt[`DTMF_ST_HELD] = (rx_st_r == dtmfg_pkg::RX_HELD);
    end else begin
      rd_nxt = 32'h0000_0000;
    end
  end

  // Bus answers: no wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `DTMF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[3:0];
    end
  end

  // Transmit digit latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_digit_r <= 4'h0;
    end else if (wr_tx) begin
      tx_digit_r <= hwdata[3:0];
    end
  end

  // Two of eight group selection from the held digit
  assign grp = digit_grp(tx_digit_r);
  assign row_term = div_term(1'b0, grp.row);
  assign col_term = div_term(1'b1, grp.col);

  // Burst timing in crystal ticks, doubled in call progress mode
  assign burst_on = ctrl_r.tone_output_enable && ctrl_r.burst_enable;
  assign bst_lim = ctrl_r.call_progress_select ?
                   CNT_W'(2 * BURST_TICKS - 1) :
                   CNT_W'(BURST_TICKS - 1);
  assign bst_end = tick && (bst_cnt_r == bst_lim);
  assign bst_done = burst_on && (bst_st_r == dtmfg_pkg::BST_PAUSE) &&
                    bst_end;

  // Digit waiting for a burst
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_go_r <= 1'b0;
    end else if (wr_tx) begin
      tx_go_r <= 1'b1;
    end else if (!burst_on || bst_st_r == dtmfg_pkg::BST_IDLE) begin
      tx_go_r <= 1'b0;
    end
  end

  // Burst and pause sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_st_r <= dtmfg_pkg::BST_IDLE;
      bst_cnt_r <= '0;
    end else if (!burst_on) begin
      bst_st_r <= dtmfg_pkg::BST_IDLE;
      bst_cnt_r <= '0;
    end else begin
      case (bst_st_r)
        dtmfg_pkg::BST_IDLE: begin
          bst_cnt_r <= '0;
          if (tx_go_r) begin
            bst_st_r <= dtmfg_pkg::BST_TONE;
          end
        end
        dtmfg_pkg::BST_TONE: begin
          if (bst_end) begin
            bst_st_r <= dtmfg_pkg::BST_PAUSE;
            bst_cnt_r <= '0;
          end else if (tick) begin
            bst_cnt_r <= bst_cnt_r + 1'b1;
          end
        end
        dtmfg_pkg::BST_PAUSE: begin
          if (bst_end) begin
            bst_st_r <= dtmfg_pkg::BST_IDLE;
            bst_cnt_r <= '0;
          end else if (tick) begin
            bst_cnt_r <= bst_cnt_r + 1'b1;
          end
        end
        default: begin
          bst_st_r <= dtmfg_pkg::BST_IDLE;
          bst_cnt_r <= '0;
        end
      endcase
    end
  end

  // Tone paths run from the same cycle the burst starts
  assign tone_run = ctrl_r.tone_output_enable &&
                    (!ctrl_r.burst_enable ||
                     bst_st_r == dtmfg_pkg::BST_TONE);

  // Row and column tone paths
  dtmfg_tone_path u_row_path (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .run(tone_run),
    .term(row_term),
    .seg_addr(row_seg)
  );
  dtmfg_tone_path u_col_path (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .run(tone_run),
    .term(col_term),
    .seg_addr(col_seg)
  );
  dtmfg_sine_rom u_row_rom (
    .hclk(hclk),
    .hresetn(hresetn),
    .addr(row_seg),
    .data(row_level)
  );
  dtmfg_sine_rom u_col_rom (
    .hclk(hclk),
    .hresetn(hresetn),
    .addr(col_seg),
    .data(column_level)
  );

  // Receiver guard timing on detector steering
  assign rx_latch = (rx_st_r == dtmfg_pkg::RX_IDLE) && tick && rxp_s2_r &&
                    !ctrl_r.call_progress_select &&
                    (rx_cnt_r == CNT_W'(REC_TICKS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r <= dtmfg_pkg::RX_IDLE;
      rx_cnt_r <= '0;
    end else if (tick) begin
      case (rx_st_r)
        dtmfg_pkg::RX_IDLE: begin
          if (rx_latch) begin
            rx_st_r <= dtmfg_pkg::RX_HELD;
            rx_cnt_r <= '0;
          end else if (rxp_s2_r && !ctrl_r.call_progress_select) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end else begin
            rx_cnt_r <= '0;
          end
        end
        dtmfg_pkg::RX_HELD: begin
          if (rxp_s2_r) begin
            rx_cnt_r <= '0;
          end else if (rx_cnt_r == CNT_W'(DO_TICKS)) begin
            rx_st_r <= dtmfg_pkg::RX_GAP;
            rx_cnt_r <= '0;
          end else begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end
        end
        dtmfg_pkg::RX_GAP: begin
          if (rx_cnt_r == CNT_W'(ID_TICKS - 1)) begin
            rx_st_r <= dtmfg_pkg::RX_IDLE;
            rx_cnt_r <= '0;
          end else begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end
        end
        default: begin
          rx_st_r <= dtmfg_pkg::RX_IDLE;
          rx_cnt_r <= '0;
        end
      endcase
    end
  end

  // Receive data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_digit_r <= 4'h0;
    end else if (rx_latch) begin
      rx_digit_r <= rxc_s2_r;
    end
  end

  // Status flags, a set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready_r <= `DTMF_TXRDY_RST;
    end else if (bst_done) begin
      tx_ready_r <= 1'b1;
    end else if (wr_tx) begin
      tx_ready_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid_r <= 1'b0;
    end else if (rx_latch) begin
      rx_valid_r <= 1'b1;
    end else if (rd_stat) begin
      rx_valid_r <= 1'b0;
    end
  end

  // Interrupt pending: new digit or transmitter ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_r <= 1'b0;
    end else if (rx_latch || bst_done) begin
      irq_pend_r <= 1'b1;
    end else if (rd_stat) begin
      irq_pend_r <= 1'b0;
    end
  end

  // Open-drain pin: square wave in call progress with burst disabled, else interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_or_tone_square_out <= 1'b0;
      interrupt_or_tone_square_oe <= 1'b0;
      tone_active <= 1'b0;
    end else begin
      interrupt_or_tone_square_out <= 1'b0;
      tone_active <= tone_run;
      if (ctrl_r.call_progress_select && !ctrl_r.burst_enable) begin
        interrupt_or_tone_square_oe <= !cpl_s2_r;
      end else begin
        interrupt_or_tone_square_oe <= ctrl_r.irq_enable &&
                                       irq_pend_r;
      end
    end
  end
endmodule : dtmfg_top

// [tb/dtmfg_line_model.sv]
// Crystal and tone detector model on the line side of the generator
`timescale 1ns/1ns
module dtmfg_line_model #(
  parameter int XTAL_HALF_NS = 140
) (
  input wire logic tone_req,
  input wire logic [3:0] code_req,
  output logic xtal_clk_pin,
  output logic rx_tone_present,
  output logic [3:0] rx_tone_code,
  output logic call_progress_level
);
  logic [3:0] last_r;
  // Crystal runs all the time, never gated between bursts
  initial begin
    xtal_clk_pin = 1'b0;
    #3;
    forever #(XTAL_HALF_NS) xtal_clk_pin = ~xtal_clk_pin;
  end
  // Comparator square wave of a call progress tone
  initial begin
    call_progress_level = 1'b0;
    forever #(7 * XTAL_HALF_NS) call_progress_level = ~call_progress_level;
  end
  // Idle code lines show the inverse of the last digit
  initial begin
    last_r = 4'h0;
    rx_tone_present = 1'b0;
    rx_tone_code = 4'hF;
  end
  always @(tone_req or code_req) begin
    if (tone_req) last_r = code_req;
    rx_tone_present = tone_req;
    rx_tone_code = tone_req ? code_req : ~last_r;
  end
endmodule : dtmfg_line_model

// [tb/dtmfg_top_asserts.sv]
// Port checker of the DTMF generator, bound to its top module
`timescale 1ns/1ns
`include "dtmfg_map.svh"
module dtmfg_chk #(
  parameter int BURST_TICKS = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic xtal_clk_pin,
  input wire logic [7:0] row_level,
  input wire logic [7:0] column_level,
  input wire logic tone_active,
  input wire logic interrupt_or_tone_square_out,
  input wire logic interrupt_or_tone_square_oe
);
  logic cw_r;
  logic xt_r;
  logic [3:0] ctl_r;
  int tk_r;
  int lim;
  // Shadow of the control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cw_r <= 1'b0;
      ctl_r <= 4'h0;
    end else begin
      cw_r <= hsel && htrans[1] && hready && hwrite &&
        haddr[7:0] == `DTMF_ADDR_CTRL;
      if (cw_r) ctl_r <= hwdata[3:0];
    end
  end
  // Crystal ticks counted over one tone run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xt_r <= 1'b0;
      tk_r <= 0;
    end else begin
      xt_r <= xtal_clk_pin;
      if (!tone_active) tk_r <= 0;
      else if (xtal_clk_pin && !xt_r) tk_r <= tk_r + 1;
    end
  end
  assign lim = ctl_r[1] ? 2 * BURST_TICKS : BURST_TICKS;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  a_pin_data_low: assert property (!interrupt_or_tone_square_out)
    else $error("open-drain data not low");
  a_read_upper: assert property (hrdata[31:4] == 28'h0)
    else $error("read data upper bits set");
  a_rest_mid: assert property (!tone_active [*4] |->
    row_level == 8'h80 && column_level == 8'h80)
    else $error("silent tone not at mid level");
  a_quiet_off: assert property (row_level != $past(row_level) |->
    row_level == 8'h80 || $past(tone_active) || $past(tone_active, 2))
    else $error("row level moved while silent");
  a_on_needs_en: assert property (tone_active |-> $past(ctl_r[0]) ||
    $past(ctl_r[0], 2) || $past(ctl_r[0], 3))
    else $error("tone active without enable");
  a_burst_len: assert property ($fell(tone_active) && ctl_r[3] &&
    ctl_r[0] |-> tk_r + 2 >= lim && tk_r <= lim + 2)
    else $error("burst length off");
  a_pause_quiet: assert property ($fell(tone_active) && ctl_r[3] &&
    ctl_r[0] |=> !tone_active [*8])
    else $error("pause not silent");
  c_burst_cp: cover property ($fell(tone_active) && ctl_r[3] && ctl_r[1]);
  c_free_tone: cover property (tone_active && !ctl_r[3]);
  c_irq_pin: cover property ($rose(interrupt_or_tone_square_oe));
endmodule : dtmfg_chk

bind dtmfg_top dtmfg_chk #(.BURST_TICKS(BURST_TICKS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .xtal_clk_pin(xtal_clk_pin), .row_level(row_level),
  .column_level(column_level), .tone_active(tone_active),
  .interrupt_or_tone_square_out(interrupt_or_tone_square_out),
  .interrupt_or_tone_square_oe(interrupt_or_tone_square_oe));

// [tb/tb_dtmf_tone_generator_burst.sv]
// Self-checking bench of the DTMF generator with burst timing
`timescale 1ns/1ns
`include "dtmfg_map.svh"
module tb_dtmf_tone_generator_burst;
  localparam int BT = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic dph = 1'b0;
  logic tone_req = 1'b0;
  logic [3:0] code_req = 4'h0;
  logic xt_d = 1'b0;
  wire hready;
  logic hresp, tone_active, pin_out, pin_oe, xtal, present, cp_lvl;
  logic [3:0] rx_code, dg;
  logic [7:0] row_level, column_level;
  logic [31:0] hrdata, r;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0] rw [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 0, 1, 2};
  logic [1:0] cl [16] = '{3, 0, 1, 2, 0, 1, 2, 0, 1, 2, 1, 0, 2, 3, 3, 3};
  logic [7:0] rdv [4] = '{`DTMF_DIV_L1, `DTMF_DIV_L2, `DTMF_DIV_L3,
    `DTMF_DIV_L4};
  logic [7:0] cdv [4] = '{`DTMF_DIV_H1, `DTMF_DIV_H2, `DTMF_DIV_H3,
    `DTMF_DIV_H4};
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int tk = 0;
  int seed = 32'h4da87355;
  int t0;

  always #5 hclk = ~hclk;

  dtmfg_top #(.BURST_TICKS(BT), .REC_TICKS(20), .DO_TICKS(5),
    .ID_TICKS(10)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .xtal_clk_pin(xtal), .rx_tone_present(present), .rx_tone_code(rx_code),
    .call_progress_level(cp_lvl), .row_level(row_level),
    .column_level(column_level), .tone_active(tone_active),
    .interrupt_or_tone_square_out(pin_out),
    .interrupt_or_tone_square_oe(pin_oe));

  // Crystal sped up so that long tone counts finish quickly
  dtmfg_line_model #(.XTAL_HALF_NS(20)) far (
    .tone_req(tone_req), .code_req(code_req), .xtal_clk_pin(xtal),
    .rx_tone_present(present), .rx_tone_code(rx_code),
    .call_progress_level(cp_lvl));

  // Crystal tick count and hang watchdog
  always @(posedge hclk) begin
    xt_d <= xtal;
    cyc <= cyc + 1;
    if (xtal && !xt_d) tk <= tk + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  // Read data monitor takes the oldest note
  always @(posedge hclk) begin
    if (dph && hready) chk("hrdata", exp_q.pop_front(),
      hrdata & msk_q.pop_front());
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    dph <= !w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    dph <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [3:0] v);
    r = $random(seed);
    bus(1'b1, a, {r[31:4], v});
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task wt(input int n);
    int s;
    s = tk;
    while (tk < s + n) @(posedge hclk);
  endtask : wt

  task rx(input logic [3:0] c, input int on, input int off);
    tone_req <= 1'b1;
    code_req <= c;
    wt(on);
    tone_req <= 1'b0;
    wt(off);
  endtask : rx

  // Segment lengths of both tones for one digit
  task seg(input logic [3:0] c);
    int tr, tc, kr, kc, i;
    logic [7:0] pr, pc;
    wr(`DTMF_ADDR_CTRL, 4'h0);
    wr(`DTMF_ADDR_TXDATA, c);
    wr(`DTMF_ADDR_CTRL, 4'h1);
    repeat (3) @(posedge hclk);
    chk("tone_active", 32'h1, {31'h0, tone_active});
    kr = 0;
    kc = 0;
    tr = 0;
    tc = 0;
    pr = row_level;
    pc = column_level;
    for (i = 0; i < 3000 && (kr < 2 || kc < 2); i++) begin
      @(posedge hclk);
      if (row_level !== pr && kr < 2) begin
        kr = kr + 1;
        if (kr == 2) chk("row_seg", {24'h0, rdv[rw[c]]}, tk - tr);
        tr = tk;
      end
      if (column_level !== pc && kc < 2) begin
        kc = kc + 1;
        if (kc == 2) chk("col_seg", {24'h0, cdv[cl[c]]}, tk - tc);
        tc = tk;
      end
      pr = row_level;
      pc = column_level;
    end
    chk("seg_changes", 32'h4, kr + kc);
  endtask : seg

  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`DTMF_ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`DTMF_ADDR_STATUS, 32'h2, 32'h7);
    rd(`DTMF_ADDR_RXDATA, 32'h0, 32'hFFFFFFFF);
    wr(8'h10, 4'hF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    wr(`DTMF_ADDR_CTRL, 4'h6);
    rd(`DTMF_ADDR_CTRL, 32'h6, 32'hFFFFFFFF);
    for (int c = 0; c < 16; c++) seg(4'(c));
    // Burst then pause, plain and call progress
    for (int j = 0; j < 2; j++) begin
      wr(`DTMF_ADDR_CTRL, 4'h0);
      wr(`DTMF_ADDR_CTRL, {2'b11, j[0], 1'b1});
      r = $random(seed);
      wr(`DTMF_ADDR_TXDATA, r[3:0]);
      t0 = tk;
      repeat (3) @(posedge hclk);
      chk("burst_start", 32'h1, {31'h0, tone_active});
      rd(`DTMF_ADDR_STATUS, 32'h0, 32'h2);
      for (int i = 0; i < 9000 && pin_oe !== 1'b1; i++) @(posedge hclk);
      t0 = tk - t0 - 2 * BT * (j + 1);
      chk("burst_pause", 32'h1, {31'h0, t0 > -3 && t0 < 4});
      rd(`DTMF_ADDR_STATUS, 32'h3, 32'h3);
      @(posedge hclk);
      chk("irq_pin", 32'h0, {31'h0, pin_oe});
      rd(`DTMF_ADDR_STATUS, 32'h2, 32'h3);
    end
    // Receiver: recognise, reject short, blocked, dropout
    wr(`DTMF_ADDR_CTRL, 4'h4);
    r = $random(seed);
    dg = r[3:0];
    rx(dg, 30, 20);
    chk("irq_pin", 32'h1, {31'h0, pin_oe});
    rd(`DTMF_ADDR_STATUS, 32'h5, 32'h5);
    rd(`DTMF_ADDR_RXDATA, {28'h0, dg}, 32'hF);
    rx(~dg, 10, 20);
    rd(`DTMF_ADDR_RXDATA, {28'h0, dg}, 32'hF);
    wr(`DTMF_ADDR_CTRL, 4'hA);
    rx(~dg, 30, 20);
    rd(`DTMF_ADDR_STATUS, 32'h0, 32'h5);
    wr(`DTMF_ADDR_CTRL, 4'h4);
    rx(~dg, 30, 3);
    rx(dg, 30, 20);
    rd(`DTMF_ADDR_STATUS, 32'h5, 32'h5);
    rd(`DTMF_ADDR_RXDATA, {28'h0, ~dg}, 32'hF);
    tally_and_finish();
  end
endmodule : tb_dtmf_tone_generator_burst
